/* File: verilog/power_mode_control.sv */
// Idle and power-down sequencing with priority registers on AXI4-Lite
//
// Functional notes
// - Instruction setting idle bit completes; CPU then stops until idle ends.
// - Idle gates CPU clock; interrupt, timer and serial clocks keep running.
// - Idle keeps every CPU register unchanged by holding its clock.
// - Idle holds port levels from entry, except with external memory: port 0 floats, port 2 shows p2_addr; address latch and program strobes high.
// - Enabled interrupt in idle clears idle bit and resumes execution.
// - Hardware reset held 24 oscillator periods ends idle.
// - Power-down stops the oscillator after the requesting instruction.
// - RAM and special registers keep contents throughout power-down.
// - Only reset or enabled external pins leave power-down.
// - Low enabled pin restarts oscillator; pin going high completes exit.
// - Both pins enabled: either low restarts; first release exits, higher priority wins.
// - After wake handler, execution continues after the power-down instruction.
// - Reset exit reinitialises special registers; interrupt exit leaves them.
// - Internal RAM survives any power-down exit.
// - Idle and power-down both set: power-down exit, both bits cleared.
// - Power-down drives both strobes low; ports 1 to 3 hold data.
// - Port 0 drives only zero when asleep, floats on external memory.
// - Upper and lower priority bits form a two-bit level, 3 highest.
// - Upper priority register at index B7h, bits 5..0 per source.
// - Upper priority bits 7 and 6 reserved; never set.
// - Setting power-down bit enters power-down; any reset clears it.
// - Idle bit cleared by hardware on interrupt or reset.
`timescale 1ns/10ps
`default_nettype none
module power_mode_control
    import pmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rst_pin,
    input wire logic ext_irq_pin_a_n,
    input wire logic ext_irq_pin_b_n,
    input wire logic timer0_irq,
    input wire logic timer1_irq,
    input wire logic serial_irq,
    input wire logic timer2_irq,
    input wire logic ext_mem,
    input wire logic ale_core,
    input wire logic program_store_strobe_core,
    input wire logic [7:0] p0_core,
    input wire logic [7:0] p0_core_oe,
    input wire logic [7:0] p1_core,
    input wire logic [7:0] p2_core,
    input wire logic [7:0] p2_addr,
    input wire logic [7:0] p3_core,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_run,
    output logic sfr_reset,
    output logic wake_valid,
    output logic [2:0] wake_src,
    output logic ale,
    output logic program_store_strobe,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe,
    output logic [7:0] port1_out,
    output logic [7:0] port2_out,
    output logic [7:0] port3_out
);
    pm_state_t state_r, state_nxt, state_new;
    logic [7:0] power_control_reg_r, irq_en_r, prio_lower_r, ext_cfg_r;
    logic [7:0] interrupt_priority_upper_r;
    logic [7:0] power_control_reg_nxt;
    logic pin_a_prev_r, pin_b_prev_r;
    logic [1:0] low_seen_r;
    logic wake_valid_r;
    logic [2:0] wake_src_r;
    logic hw_rst;
    logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [11:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic ale_r, pss_r;
    logic [7:0] p0_data_r, port0_out_r, port0_oe_r, port1_r, port2_r, port3_r;

    // Hardware reset qualifier
    reset_filter u_reset_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .rst_pin(rst_pin),
        .rst_pulse(hw_rst)
    );

    // Interrupt events per source; external pins are active low
    wire irq_global = irq_en_r[IRQ_GLOBAL_BIT];
    wire ext_a_evt = ext_cfg_r[EXT_A_EDGE_BIT] ? (pin_a_prev_r & ~ext_irq_pin_a_n)
        : ~ext_irq_pin_a_n;
    wire ext_b_evt = ext_cfg_r[EXT_B_EDGE_BIT] ? (pin_b_prev_r & ~ext_irq_pin_b_n)
        : ~ext_irq_pin_b_n;
    wire [NUM_SRC-1:0] raw_evt = {timer2_irq, serial_irq, timer1_irq, ext_b_evt,
        timer0_irq, ext_a_evt};
    wire [NUM_SRC-1:0] idle_pending = raw_evt & irq_en_r[NUM_SRC-1:0] & {NUM_SRC{irq_global}};
    // Only the two external pins count in power-down, level or edge alike
    wire [1:0] ext_low_en = {~ext_irq_pin_b_n & irq_en_r[SRC_EXT1],
        ~ext_irq_pin_a_n & irq_en_r[SRC_EXT0]} & {2{irq_global}};
    wire [1:0] pin_high = {ext_irq_pin_b_n, ext_irq_pin_a_n};
    wire pd_release = |(low_seen_r & pin_high);
    wire [NUM_SRC-1:0] pd_pending = {3'h0, low_seen_r[1], 1'b0, low_seen_r[0]};
    wire in_pd = (state_r == ST_PD_STOP) || (state_r == ST_PD_WAKE);

    // Arbitration among idle events, or among pins seen low in power-down
    wire [NUM_SRC-1:0] arb_in = (state_r == ST_PD_WAKE) ? pd_pending : idle_pending;
    wire grant_valid;
    wire [2:0] grant_src;
    prio_arbiter u_prio_arbiter (
        .pending(arb_in),
        .prio_upper(interrupt_priority_upper_r[NUM_SRC-1:0]),
        .prio_lower(prio_lower_r[NUM_SRC-1:0]),
        .grant_valid(grant_valid),
        .grant_src(grant_src)
    );

    wire wake_fire = ((state_r == ST_IDLE) && grant_valid) ||
        ((state_r == ST_PD_WAKE) && pd_release);

    // Mode sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (power_control_reg_r[PWR_PD_BIT]) begin
                    state_nxt = ST_PD_STOP;
                end else if (power_control_reg_r[PWR_IDLE_BIT]) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (grant_valid) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_PD_STOP: begin
                if (|ext_low_en) begin
                    state_nxt = ST_PD_WAKE;
                end
            end
            ST_PD_WAKE: begin
                if (pd_release) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end
    assign state_new = hw_rst ? ST_RUN : state_nxt;
    wire lp_new = (state_new != ST_RUN);
    wire idle_new = (state_new == ST_IDLE);

    // Clock gating outputs
    assign cpu_clk_en = (state_r == ST_RUN);
    assign osc_run = (state_r != ST_PD_STOP);
    assign periph_clk_en = osc_run;
    assign sfr_reset = hw_rst;
    assign wake_valid = wake_valid_r;
    assign wake_src = wake_src_r;

    // Register bus decode
    wire [7:0] wr_idx = aw_addr_r[9:2];
    wire wr_in_range = (aw_addr_r[11:10] == 2'h0);
    wire wr_commit = aw_have_r && w_have_r && !bvalid_r;
    wire wr_known = wr_in_range && ((wr_idx == IDX_PWR_CTRL) || (wr_idx == IDX_IRQ_EN) ||
        (wr_idx == IDX_PRIO_LOWER) || (wr_idx == IDX_EXT_CFG) || (wr_idx == IDX_PRIO_UPPER));
    wire wr_refuse = in_pd;
    wire wr_en = wr_commit && wr_known && !wr_refuse && w_lane0_r;
    wire [1:0] wr_resp = !wr_known ? RESP_DECERR : wr_refuse ? RESP_SLVERR : RESP_OKAY;
    wire [7:0] rd_idx = araddr[9:2];
    wire rd_in_range = (araddr[11:10] == 2'h0);
    wire [7:0] status_byte = {1'b0, wake_src_r, state_r};
    wire rd_known = rd_in_range && ((rd_idx == IDX_PWR_CTRL) || (rd_idx == IDX_IRQ_EN) ||
        (rd_idx == IDX_PRIO_LOWER) || (rd_idx == IDX_EXT_CFG) ||
        (rd_idx == IDX_STATUS) || (rd_idx == IDX_PRIO_UPPER));
    wire [7:0] rd_byte = !rd_in_range ? 8'h00 :
        (rd_idx == IDX_PWR_CTRL) ? power_control_reg_r :
        (rd_idx == IDX_IRQ_EN) ? irq_en_r :
        (rd_idx == IDX_PRIO_LOWER) ? prio_lower_r :
        (rd_idx == IDX_EXT_CFG) ? ext_cfg_r :
        (rd_idx == IDX_STATUS) ? status_byte :
        (rd_idx == IDX_PRIO_UPPER) ? interrupt_priority_upper_r : 8'h00;

    assign awready = !aw_have_r && !bvalid_r;
    assign wready = !w_have_r && !bvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // Write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_addr_r <= 12'h000;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                w_data_r <= wdata[7:0];
                w_lane0_r <= wstrb[0];
            end
            if (wr_commit) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_resp;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_known ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Mode bits: hardware clears on wake, a software write in the same cycle wins
    always_comb begin
        power_control_reg_nxt = power_control_reg_r;
        if (wake_fire) begin
            power_control_reg_nxt[PWR_IDLE_BIT] = 1'b0;
            power_control_reg_nxt[PWR_PD_BIT] = 1'b0;
        end
        if (wr_en && (wr_idx == IDX_PWR_CTRL)) begin
            power_control_reg_nxt = w_data_r & PWR_CTRL_MASK;
        end
    end

    // Special registers: reinitialised by either reset, kept otherwise; RAM lies outside
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            power_control_reg_r <= PWR_CTRL_RST;
            irq_en_r <= IRQ_EN_RST;
            prio_lower_r <= PRIO_RST;
            interrupt_priority_upper_r <= PRIO_RST;
            ext_cfg_r <= EXT_CFG_RST;
        end else begin
            power_control_reg_r <= power_control_reg_nxt;
            if (wr_en && (wr_idx == IDX_IRQ_EN)) begin
                irq_en_r <= w_data_r & IRQ_EN_MASK;
            end
            if (wr_en && (wr_idx == IDX_PRIO_LOWER)) begin
                prio_lower_r <= w_data_r & PRIO_MASK;
            end
            if (wr_en && (wr_idx == IDX_PRIO_UPPER)) begin
                interrupt_priority_upper_r <= w_data_r & PRIO_MASK;
            end
            if (wr_en && (wr_idx == IDX_EXT_CFG)) begin
                ext_cfg_r <= w_data_r & EXT_CFG_MASK;
            end
        end
    end

    // State, pin history and wake report
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_RUN;
            pin_a_prev_r <= 1'b1;
            pin_b_prev_r <= 1'b1;
            low_seen_r <= 2'h0;
            wake_valid_r <= 1'b0;
            wake_src_r <= 3'h0;
        end else begin
            state_r <= state_new;
            pin_a_prev_r <= ext_irq_pin_a_n;
            pin_b_prev_r <= ext_irq_pin_b_n;
            low_seen_r <= (in_pd && !hw_rst) ? (low_seen_r | ext_low_en) : 2'h0;
            wake_valid_r <= wake_fire && !hw_rst;
            if (wake_fire && !hw_rst) begin
                wake_src_r <= grant_src;
            end
        end
    end

    // Port 0 drives only zeros asleep, floats with external program memory
    wire [7:0] p0_data_nxt = lp_new ? p0_data_r : p0_core;
    wire [7:0] p0_oe_nxt = !lp_new ? p0_core_oe : ext_mem ? 8'h00 : ~p0_data_nxt;
    wire [7:0] p2_nxt = (idle_new && ext_mem) ? p2_addr : lp_new ? port2_r : p2_core;
    // Strobes high in idle, low in power-down
    wire ale_nxt = idle_new ? 1'b1 : lp_new ? 1'b0 : ale_core;
    wire pss_nxt = idle_new ? 1'b1 : lp_new ? 1'b0 : program_store_strobe_core;

    // Port 0 data and ports 1 to 3 hold their entry value while asleep, except port 2, which shows p2_addr in idle with external memory
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p0_data_r <= 8'hFF;
            port0_out_r <= 8'h00;
            port0_oe_r <= 8'h00;
            port1_r <= 8'hFF;
            port2_r <= 8'hFF;
            port3_r <= 8'hFF;
            ale_r <= 1'b1;
            pss_r <= 1'b1;
        end else begin
            p0_data_r <= p0_data_nxt;
            port0_out_r <= lp_new ? 8'h00 : p0_core;
            port0_oe_r <= p0_oe_nxt;
            port1_r <= lp_new ? port1_r : p1_core;
            port2_r <= p2_nxt;
            port3_r <= lp_new ? port3_r : p3_core;
            ale_r <= ale_nxt;
            pss_r <= pss_nxt;
        end
    end
    assign port0_out = port0_out_r;
    assign port0_oe = port0_oe_r;
    assign port1_out = port1_r;
    assign port2_out = port2_r;
    assign port3_out = port3_r;
    assign ale = ale_r;
    assign program_store_strobe = pss_r;

    // Checks on the sequencing
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_ENTRY_IDLE: assert property ((state_r == ST_RUN) && power_control_reg_r[PWR_IDLE_BIT] &&
        !power_control_reg_r[PWR_PD_BIT] && !hw_rst |=> (state_r == ST_IDLE) && !cpu_clk_en)
        else $error("idle not entered after idle bit set");
    AST_IDLE_CLOCKS: assert property ((state_r == ST_IDLE) |-> !cpu_clk_en && periph_clk_en)
        else $error("clock gating wrong in idle");
    AST_IDLE_HOLD: assert property ((state_r == ST_IDLE) [*2] |-> $stable(port1_out) &&
        $stable(port3_out) && ale && program_store_strobe && !cpu_clk_en)
        else $error("idle pins not held");
    AST_IDLE_WAKE: assert property ((state_r == ST_IDLE) && grant_valid && !hw_rst |=>
        (state_r == ST_RUN) && wake_valid && !power_control_reg_r[PWR_IDLE_BIT])
        else $error("idle not left on enabled interrupt");
    AST_HW_RESET: assert property (hw_rst |=> (state_r == ST_RUN) &&
        (power_control_reg_r == PWR_CTRL_RST) && (interrupt_priority_upper_r == PRIO_RST))
        else $error("hardware reset did not reinitialise");
    AST_PD_OSC: assert property ((state_r == ST_PD_STOP) |-> !osc_run && !cpu_clk_en)
        else $error("oscillator running in power-down");
    AST_PD_REFUSE: assert property (wr_commit && in_pd && !hw_rst |=>
        (bresp == RESP_SLVERR || bresp == RESP_DECERR) && $stable(interrupt_priority_upper_r))
        else $error("register changed during power-down");
    AST_PD_RESTART: assert property ((state_r == ST_PD_STOP) && (|ext_low_en) && !hw_rst |=>
        osc_run && (state_r == ST_PD_WAKE))
        else $error("oscillator not restarted by pin");
    AST_PD_EXIT: assert property ((state_r == ST_PD_WAKE) && pd_release && !hw_rst |=>
        (state_r == ST_RUN) && wake_valid && (power_control_reg_r[1:0] == 2'h0))
        else $error("power-down exit incomplete");
    AST_PD_STROBES: assert property (in_pd |-> !ale && !program_store_strobe)
        else $error("strobes not low in power-down");
    AST_P0_ZERO: assert property ((state_r != ST_RUN) |-> (port0_out == 8'h00))
        else $error("port 0 drives a one while asleep");
    AST_PRIO_RSVD: assert property (interrupt_priority_upper_r[7:6] == 2'h0)
        else $error("reserved priority bits set");

    COV_IDLE_WAKE: cover property ((state_r == ST_IDLE) ##1 wake_valid);
    COV_PD_WAKE: cover property ((state_r == ST_PD_WAKE) ##1 wake_valid);
    COV_PD_RESET: cover property (in_pd && hw_rst);
    COV_BOTH_BITS: cover property ((state_r == ST_RUN) && (power_control_reg_r[1:0] == 2'h3));
endmodule
`default_nettype wire

/* File: shared/pmc_pkg.sv */
// Constants, register map and state encoding for the power mode controller
package pmc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWR_CTRL = 8'h40;
    localparam logic [7:0] IDX_IRQ_EN = 8'h41;
    localparam logic [7:0] IDX_PRIO_LOWER = 8'h42;
    localparam logic [7:0] IDX_EXT_CFG = 8'h43;
    localparam logic [7:0] IDX_STATUS = 8'h44;
    localparam logic [7:0] IDX_PRIO_UPPER = 8'hB7;

    // Power control register fields
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_PD_BIT = 1;
    localparam int PWR_FLAG_A_BIT = 2;
    localparam int PWR_FLAG_B_BIT = 3;
    localparam logic [7:0] PWR_CTRL_MASK = 8'h0F;

    // Interrupt enable and source bit positions
    localparam int IRQ_GLOBAL_BIT = 7;
    localparam int NUM_SRC = 6;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_TIMER2 = 5;
    localparam logic [7:0] IRQ_EN_MASK = 8'hBF;
    localparam logic [7:0] PRIO_MASK = 8'h3F;

    // External pin configuration fields (1 = edge, 0 = level)
    localparam int EXT_A_EDGE_BIT = 0;
    localparam int EXT_B_EDGE_BIT = 1;
    localparam logic [7:0] EXT_CFG_MASK = 8'h03;

    // Reset values
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] EXT_CFG_RST = 8'h00;

    // Reset hold time; aclk is the oscillator
    localparam int OSC_PER_MACHINE_CYCLE = 12;
    localparam int RST_HOLD_MACHINE_CYCLES = 2;
    localparam int RST_HOLD_CYCLES = RST_HOLD_MACHINE_CYCLES * OSC_PER_MACHINE_CYCLE;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_IDLE = 4'h2,
        ST_PD_STOP = 4'h4,
        ST_PD_WAKE = 4'h8
    } pm_state_t;
endpackage

/* File: verilog/reset_filter.sv */
// Qualifies the hardware reset pin by its hold time
`timescale 1ns/10ps
`default_nettype none
module reset_filter
    import pmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rst_pin,
    output logic rst_pulse
);
    localparam logic [4:0] HOLD_LAST = 5'(RST_HOLD_CYCLES - 1);
    localparam logic [4:0] HOLD_DONE = 5'(RST_HOLD_CYCLES);

    logic [4:0] hold_cnt_r;
    logic [4:0] hold_cnt_nxt;
    logic rst_pulse_r;

    // Count consecutive high samples, saturate once qualified
    assign hold_cnt_nxt = !rst_pin ? 5'h00 :
        (hold_cnt_r == HOLD_DONE) ? HOLD_DONE : 5'(hold_cnt_r + 5'h01);
    assign rst_pulse = rst_pulse_r;

    // One pulse per assertion, on the last qualifying sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_r <= 5'h00;
            rst_pulse_r <= 1'b0;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
            rst_pulse_r <= rst_pin && (hold_cnt_r == HOLD_LAST);
        end
    end
endmodule
`default_nettype wire

/* File: verilog/prio_arbiter.sv */
// Picks the winning interrupt source by two-bit level, then polling order
`timescale 1ns/10ps
`default_nettype none
module prio_arbiter
    import pmc_pkg::*;
(
    input wire logic [NUM_SRC-1:0] pending,
    input wire logic [NUM_SRC-1:0] prio_upper,
    input wire logic [NUM_SRC-1:0] prio_lower,
    output logic grant_valid,
    output logic [2:0] grant_src
);
    logic [1:0] level [NUM_SRC];

    // Level per source: upper bit over lower bit, 3 is highest
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_level
            assign level[g] = {prio_upper[g], prio_lower[g]};
        end
    endgenerate

    // Strict compare keeps the lowest index among equal levels
    always_comb begin
        logic [1:0] best;
        best = 2'h0;
        grant_valid = 1'b0;
        grant_src = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pending[i] && (!grant_valid || (level[i] > best))) begin
                grant_valid = 1'b1;
                grant_src = 3'(i);
                best = level[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/pmc_core_model.sv */
// Core-side model: strobes and port values that change every cycle
`timescale 1ns/10ps
`default_nettype none
module pmc_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    output logic ale_core,
    output logic pss_core,
    output logic [7:0] p0,
    output logic [7:0] p0_oe,
    output logic [7:0] p1,
    output logic [7:0] p2,
    output logic [7:0] p3
);
    logic [7:0] cnt_r;
    // Free count, so a port that fails to freeze shows at once
    always_ff @(posedge aclk) cnt_r <= aresetn ? cnt_r + 8'h01 : 8'h00;
    // Core drives toggling strobes and moving port data
    assign ale_core = cnt_r[0];
    assign pss_core = ~cnt_r[0];
    assign p0 = cnt_r;
    assign p0_oe = 8'hFF;
    assign p1 = ~cnt_r;
    assign p2 = cnt_r + 8'h11;
    assign p3 = cnt_r ^ 8'hA5;
endmodule
`default_nettype wire

/* File: dv/power_mode_control_tb.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module power_mode_control_tb;
    import pmc_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r, bresp_dummy;
    logic rst_pin = 0, xa_n = 1, xb_n = 1, t0 = 0, xm = 0;
    logic awready, wready, bvalid, arready, rvalid, cpu_clk_en, periph_clk_en, osc_run;
    logic sfr_reset, wake_valid, ale, pss, ale_c, pss_c;
    logic [2:0] wake_src;
    logic [7:0] p0c, p0e, p1c, p2c, p3c, po0, poe, po1, po2, po3;
    int n_errors = 0, checked = 0;
    localparam logic [11:0] PWR = 12'h100, EN = 12'h104, PL = 12'h108, PU = 12'h2DC;
    logic [11:0] ra [4] = '{PU, PL, PU, 12'h3FC};
    logic [7:0] rw [4] = '{8'hFF, 8'h15, 8'h05, 8'h5A};
    logic [7:0] re [4] = '{8'h3F, 8'h15, 8'h05, 8'h00};
    logic [1:0] rr [4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_DECERR};
    always #50 aclk = ~aclk;
    pmc_core_model u_pmc_core_model (.aclk(aclk), .aresetn(aresetn), .ale_core(ale_c),
        .pss_core(pss_c), .p0(p0c), .p0_oe(p0e), .p1(p1c), .p2(p2c), .p3(p3c));
    power_mode_control u_power_mode_control (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rst_pin(rst_pin), .ext_irq_pin_a_n(xa_n), .ext_irq_pin_b_n(xb_n),
        .timer0_irq(t0), .timer1_irq(1'b0), .serial_irq(1'b0), .timer2_irq(1'b0),
        .ext_mem(xm), .ale_core(ale_c), .program_store_strobe_core(pss_c), .p0_core(p0c),
        .p0_core_oe(p0e), .p1_core(p1c), .p2_core(p2c), .p2_addr(8'h3C), .p3_core(p3c),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
        .sfr_reset(sfr_reset), .wake_valid(wake_valid), .wake_src(wake_src), .ale(ale),
        .program_store_strobe(pss), .port0_out(po0), .port0_oe(poe), .port1_out(po1),
        .port2_out(po2), .port3_out(po3));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Write: address and data offered together, response held ready until seen
    task automatic wr(input logic [11:0] a, input logic [7:0] x, output logic [1:0] b);
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, x}; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 0; wvalid <= 0;
        do @(negedge aclk); while (!bvalid);
        b = bresp;
        @(posedge aclk) bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk) arvalid <= 0;
        do @(negedge aclk); while (!rvalid);
        q = rdata; r = rresp;
        @(posedge aclk) rready <= 0;
    endtask
    task automatic wait_wake();
        do @(negedge aclk); while (!wake_valid);
    endtask
    // Watchdog cuts a hang short
    initial begin
        #2000000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk) chk("cpu_clk_en", cpu_clk_en, 1);
        // Register rows: write, then read back value and response
        for (int i = 0; i < 4; i++) begin
            wr(ra[i], rw[i], bresp_dummy);
            chk("bresp", bresp_dummy, rr[i]);
            rd(ra[i], d);
            chk("rdata", d, re[i]);
            chk("rresp", r, rr[i]);
        end
        // Idle entry and wake by an enabled timer
        wr(EN, 8'h82, r);
        wr(PWR, 8'h05, r);
        repeat (3) @(negedge aclk);
        chk("cpu_clk_en", cpu_clk_en, 0);
        chk("periph_clk_en", periph_clk_en, 1);
        chk("strobes", {ale, pss}, 2'b11);
        d = {po0, poe, po1, po3};
        repeat (2) @(negedge aclk);
        chk("ports", {po0, poe, po1, po3}, d);
        chk("port0_out", po0, 8'h00);
        rd(12'h110, d);
        chk("status", d, 32'h2);
        @(posedge aclk) t0 <= 1;
        wait_wake();
        chk("wake_src", wake_src, SRC_TIMER0);
        @(posedge aclk) t0 <= 0;
        rd(PWR, d);
        chk("pwr after idle", d, 32'h4);
        // Power-down with both bits, both pins, ext b ranked higher
        wr(EN, 8'h85, r);
        wr(PU, 8'h04, r);
        wr(PL, 8'h04, r);
        wr(PWR, 8'h03, r);
        repeat (3) @(negedge aclk);
        chk("osc_run", osc_run, 0);
        chk("strobes", {ale, pss}, 2'b00);
        wr(PL, 8'h00, r);
        chk("pd write", r, RESP_SLVERR);
        @(posedge aclk);
        xa_n <= 0; xb_n <= 0;
        repeat (30) @(negedge aclk);
        chk("osc_run", osc_run, 1);
        @(posedge aclk) xa_n <= 1;
        wait_wake();
        chk("wake_src", wake_src, SRC_EXT1);
        @(posedge aclk) xb_n <= 1;
        rd(PWR, d);
        chk("pwr after pd", d, 32'h0);
        rd(PL, d);
        chk("prio kept", d, 32'h4);
        // Edge-mode pin a wakes idle
        wr(12'h10C, 8'h01, r);
        wr(PWR, 8'h01, r);
        @(posedge aclk) xa_n <= 0;
        wait_wake();
        chk("wake_src edge", wake_src, SRC_EXT0);
        @(posedge aclk) xa_n <= 1;
        // Hardware reset held 24 periods ends idle and reloads registers
        xm <= 1;
        wr(PWR, 8'h01, r);
        repeat (2) @(negedge aclk);
        chk("port0_oe ext", poe, 8'h00);
        chk("port2_out ext", po2, 8'h3C);
        @(posedge aclk) rst_pin <= 1;
        do @(negedge aclk); while (!sfr_reset);
        @(posedge aclk) rst_pin <= 0;
        repeat (2) @(negedge aclk);
        chk("cpu_clk_en", cpu_clk_en, 1);
        rd(PL, d);
        chk("prio reset", d, PRIO_RST);
        rd(PWR, d);
        chk("pwr reset", d, PWR_CTRL_RST);
        summarize();
    end
endmodule
`default_nettype wire
